// *** rtl/cond_map.svh ***
// Register offsets, field positions, reset values and arithmetic constants
`ifndef COND_MAP_SVH
`define COND_MAP_SVH
// ****************************************
// Register word indices on the register port
// ****************************************
`define IDX_CONFIG 4'h0
`define IDX_THIRD_CONFIGURATION 4'h1
`define IDX_INTEGRATOR_COEFFICIENT 4'h2
`define IDX_PHASE_A_VOLTAGE_GAIN 4'h3
`define IDX_PHASE_B_VOLTAGE_GAIN 4'h4
`define IDX_PHASE_C_VOLTAGE_GAIN 4'h5
`define IDX_PHASE_A_VOLTAGE_SAMPLE 4'h6
`define IDX_PHASE_B_VOLTAGE_SAMPLE 4'h7
`define IDX_PHASE_C_VOLTAGE_SAMPLE 4'h8
`define IDX_FIRST_STATUS 4'h9
`define IDX_FIRST_INTERRUPT_MASK 4'hA
// ****************************************
// Field positions
// ****************************************
`define BIT_PHASE_INTEGRATOR_ENABLE 0
`define BIT_DC_FILTER_ENABLE 0
`define BIT_NEUTRAL_INTEGRATOR_ENABLE 3
`define BIT_SAMPLE_READY_FLAG 17
`define LSB_PHASE_A_VOLTAGE_ROUTE 8
`define LSB_PHASE_B_VOLTAGE_ROUTE 10
`define LSB_PHASE_C_VOLTAGE_ROUTE 12
// ****************************************
// Reset values and arithmetic constants
// ****************************************
`define RST_CONFIG 16'h0000
`define RST_THIRD_CONFIGURATION 8'h01
`define RST_INTEGRATOR_COEFFICIENT 24'h00_0000
`define RST_VOLTAGE_GAIN 24'h00_0000
`define GAIN_UNITY 25'h080_0000
`define GAIN_SHIFT 23
`define HPF_SHIFT 10
`define FIFO_DEPTH 8
`endif

// *** rtl/cond_pkg.sv ***
// Types shared by the channel conditioning design
package cond_pkg;
   typedef logic signed [23:0] sample_t;
   typedef enum logic [1:0] {
      ROUTE_HOME = 2'b00,
      ROUTE_NEXT = 2'b01,
      ROUTE_PREV = 2'b10,
      ROUTE_SAME = 2'b11
   } route_t;
   typedef enum logic [1:0] {
      PATH_A = 2'b00,
      PATH_B = 2'b01,
      PATH_C = 2'b10,
      PATH_NONE = 2'b11
   } path_t;
endpackage

// *** rtl/channel_conditioning.sv ***
// Channel conditioning: integrators, voltage gain, dc filter, sampling, routing
// Operation
// - Config bit 0 governs all three phase integrators; reset 0 means enabled.
// - Neutral integrator has its own enable, third configuration bit 3.
// - Neutral enable resets 0 (off); writing 1 turns neutral integration on.
// - Integrator coefficient is zero after reset.
// - Coefficient is ignored while integration is off.
// - Coefficient reads as 32 bits, top four zero, sign-extended to 28.
// - With integrator off, current samples pass straight through.
// - Voltage samples are 24-bit two's complement words at 8 kSPS.
// - Voltage scaled by one plus gain over two to the 23rd.
// - Gain change affects all downstream results and captured samples.
// - Gain registers read as 32 bits, top four zero, sign-extended to 28.
// - Voltage paths have dc-removing filters enabled by third configuration bit 0.
// - Filter enable resets to 1; clearing it disables every filter.
// - Samples taken after the filter into three 24-bit sample registers.
// - Sample-ready flag, first status bit 17, sets on fresh samples.
// - With first mask bit 17 set, ready flag raises the interrupt.
// - Sample registers read back sign-extended to 32 bits.
// - Phase A route: 00 to A, 01 to B, 10 to C, 11 as 00.
// - Phase B route: 00 to B, 01 to C, 10 to A, 11 as 00.
// - Phase C route: 00 to C, 01 to A, 10 to B, 11 as 00.
// - Each path pairs its routed voltage with its own phase current.
`timescale 1ns/1ps
`include "cond_map.svh"

// ****************************************
// Sample buffer
// ****************************************
module sample_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and control
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic ce,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr_r;
   logic [PW-1:0] rd_ptr_r;
   logic [PW:0] count_r;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   wire full = (count_r == (PW+1)'(DEPTH));
   wire empty = (count_r == '0);

   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem[rd_ptr_r];

   always_ff @(posedge mclk) begin
      if (ce && push) mem[wr_ptr_r] <= in_data;
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else if (ce) begin
         if (push) wr_ptr_r <= (wr_ptr_r == PW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
         if (pop) rd_ptr_r <= (rd_ptr_r == PW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
         if (push && !pop) begin
            count_r <= count_r + 1'b1;
         end else if (pop && !push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end
endmodule // sample_fifo

// ****************************************
// Conditioning top
// ****************************************
module channel_conditioning (
   // Clock, reset, enable
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic ce,
   // Register port behind the serial interface
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   // Converter samples, 8 kSPS strobe
   input wire logic adc_valid,
   output logic adc_ready,
   input wire logic [23:0] phase_a_voltage_input,
   input wire logic [23:0] phase_b_voltage_input,
   input wire logic [23:0] phase_c_voltage_input,
   input wire logic [23:0] phase_a_current_input,
   input wire logic [23:0] phase_b_current_input,
   input wire logic [23:0] phase_c_current_input,
   input wire logic [23:0] neutral_current_input,
   // Computational path outputs
   output logic path_valid,
   input wire logic path_ready,
   output logic [23:0] path_a_voltage,
   output logic [23:0] path_b_voltage,
   output logic [23:0] path_c_voltage,
   output logic [23:0] path_a_current,
   output logic [23:0] path_b_current,
   output logic [23:0] path_c_current,
   output logic [23:0] path_n_current,
   // Data-ready interrupt, active low
   output logic sample_irq_n
);
   // ****************************************
   // Helper arithmetic
   // ****************************************
   function automatic logic [23:0] sat24(input logic signed [31:0] v);
      return (v > 32'sh007F_FFFF) ? 24'h7F_FFFF : (v < -32'sh0080_0000) ? 24'h80_0000 : v[23:0];
   endfunction

   // Scale by one plus gain over 2^23
   function automatic logic [23:0] gain_apply(input logic [23:0] x, input logic [23:0] g);
      logic signed [24:0] mult;
      logic signed [49:0] prod;
      mult = $signed({g[23], g}) + $signed(`GAIN_UNITY);
      prod = $signed(x) * mult;
      return sat24(32'(prod >>> `GAIN_SHIFT));
   endfunction

   // One step of the leaky digital integrator
   function automatic logic [31:0] integ_step(input logic [31:0] acc, input logic [23:0] x,
                                             input logic [23:0] c);
      logic signed [55:0] leak;
      leak = $signed(acc) * $signed(c);
      return acc + {{8{x[23]}}, x} + 32'(leak >>> `GAIN_SHIFT);
   endfunction

   // Destination path of one phase voltage
   function automatic cond_pkg::path_t route_dest(input logic [1:0] code, input logic [1:0] home);
      cond_pkg::path_t d;
      logic [1:0] nxt;
      logic [1:0] prv;
      nxt = (home == 2'b10) ? 2'b00 : home + 2'b01;
      prv = (home == 2'b00) ? 2'b10 : home - 2'b01;
      case (cond_pkg::route_t'(code))
         cond_pkg::ROUTE_NEXT: d = cond_pkg::path_t'(nxt);
         cond_pkg::ROUTE_PREV: d = cond_pkg::path_t'(prv);
         cond_pkg::ROUTE_HOME: d = cond_pkg::path_t'(home);
         default: d = cond_pkg::path_t'(home);
      endcase
      return d;
   endfunction

   // Word view: top four zero, sign-extended to 28 bits
   function automatic logic [31:0] word28(input logic [23:0] v);
      return {4'h0, {4{v[23]}}, v};
   endfunction

   // ****************************************
   // Registers
   // ****************************************
   logic [15:0] config_r;
   logic [7:0] third_configuration_r;
   logic [23:0] integrator_coefficient_r;
   logic [23:0] phase_a_voltage_gain_r;
   logic [23:0] phase_b_voltage_gain_r;
   logic [23:0] phase_c_voltage_gain_r;
   logic [23:0] phase_a_voltage_sample_r;
   logic [23:0] phase_b_voltage_sample_r;
   logic [23:0] phase_c_voltage_sample_r;
   logic sample_ready_flag_r;
   logic ready_mask_r;
   logic [31:0] dc_a_r;
   logic [31:0] dc_b_r;
   logic [31:0] dc_c_r;
   logic [31:0] int_a_r;
   logic [31:0] int_b_r;
   logic [31:0] int_c_r;
   logic [31:0] int_n_r;

   // ****************************************
   // Decode
   // ****************************************
   wire wr_cfg = reg_wr && (reg_addr == `IDX_CONFIG);
   wire wr_cfg3 = reg_wr && (reg_addr == `IDX_THIRD_CONFIGURATION);
   wire wr_coef = reg_wr && (reg_addr == `IDX_INTEGRATOR_COEFFICIENT);
   wire wr_gain_a = reg_wr && (reg_addr == `IDX_PHASE_A_VOLTAGE_GAIN);
   wire wr_gain_b = reg_wr && (reg_addr == `IDX_PHASE_B_VOLTAGE_GAIN);
   wire wr_gain_c = reg_wr && (reg_addr == `IDX_PHASE_C_VOLTAGE_GAIN);
   wire wr_status = reg_wr && (reg_addr == `IDX_FIRST_STATUS);
   wire wr_mask = reg_wr && (reg_addr == `IDX_FIRST_INTERRUPT_MASK);
   wire ready_clear = wr_status && reg_wdata[`BIT_SAMPLE_READY_FLAG];

   // Control fields, sampled only on an accepted sample
   wire phase_integrator_enable = config_r[`BIT_PHASE_INTEGRATOR_ENABLE];
   wire phase_int_on = !phase_integrator_enable;
   wire neutral_int_on = third_configuration_r[`BIT_NEUTRAL_INTEGRATOR_ENABLE];
   wire dc_filter_enable = third_configuration_r[`BIT_DC_FILTER_ENABLE];
   wire [1:0] phase_a_voltage_route = config_r[`LSB_PHASE_A_VOLTAGE_ROUTE +: 2];
   wire [1:0] phase_b_voltage_route = config_r[`LSB_PHASE_B_VOLTAGE_ROUTE +: 2];
   wire [1:0] phase_c_voltage_route = config_r[`LSB_PHASE_C_VOLTAGE_ROUTE +: 2];

   // Whole sample handled in one cycle, so settings switch between samples
   wire take = adc_valid && adc_ready;

   // ****************************************
   // Voltage datapath
   // ****************************************
   wire [23:0] va_gain = gain_apply(phase_a_voltage_input, phase_a_voltage_gain_r);
   wire [23:0] vb_gain = gain_apply(phase_b_voltage_input, phase_b_voltage_gain_r);
   wire [23:0] vc_gain = gain_apply(phase_c_voltage_input, phase_c_voltage_gain_r);

   // Dc estimate keeps 8 fractional bits
   wire [31:0] va_dc_err = {va_gain, 8'h00} - dc_a_r;
   wire [31:0] vb_dc_err = {vb_gain, 8'h00} - dc_b_r;
   wire [31:0] vc_dc_err = {vc_gain, 8'h00} - dc_c_r;
   wire [31:0] dc_a_nxt = dc_a_r + 32'($signed(va_dc_err) >>> `HPF_SHIFT);
   wire [31:0] dc_b_nxt = dc_b_r + 32'($signed(vb_dc_err) >>> `HPF_SHIFT);
   wire [31:0] dc_c_nxt = dc_c_r + 32'($signed(vc_dc_err) >>> `HPF_SHIFT);
   wire [23:0] va_hpf = dc_filter_enable ? sat24($signed(va_dc_err) >>> 8) : va_gain;
   wire [23:0] vb_hpf = dc_filter_enable ? sat24($signed(vb_dc_err) >>> 8) : vb_gain;
   wire [23:0] vc_hpf = dc_filter_enable ? sat24($signed(vc_dc_err) >>> 8) : vc_gain;

   // ****************************************
   // Voltage routing
   // ****************************************
   wire cond_pkg::path_t dest_a = route_dest(phase_a_voltage_route, 2'b00);
   wire cond_pkg::path_t dest_b = route_dest(phase_b_voltage_route, 2'b01);
   wire cond_pkg::path_t dest_c = route_dest(phase_c_voltage_route, 2'b10);

   // Lowest phase wins a shared path; an unfed path carries zero
   wire [23:0] routed_a = (dest_a == cond_pkg::PATH_A) ? va_hpf :
                          (dest_b == cond_pkg::PATH_A) ? vb_hpf :
                          (dest_c == cond_pkg::PATH_A) ? vc_hpf : 24'h00_0000;
   wire [23:0] routed_b = (dest_a == cond_pkg::PATH_B) ? va_hpf :
                          (dest_b == cond_pkg::PATH_B) ? vb_hpf :
                          (dest_c == cond_pkg::PATH_B) ? vc_hpf : 24'h00_0000;
   wire [23:0] routed_c = (dest_a == cond_pkg::PATH_C) ? va_hpf :
                          (dest_b == cond_pkg::PATH_C) ? vb_hpf :
                          (dest_c == cond_pkg::PATH_C) ? vc_hpf : 24'h00_0000;

   // ****************************************
   // Current integrators
   // ****************************************
   wire [31:0] int_a_nxt = integ_step(int_a_r, phase_a_current_input, integrator_coefficient_r);
   wire [31:0] int_b_nxt = integ_step(int_b_r, phase_b_current_input, integrator_coefficient_r);
   wire [31:0] int_c_nxt = integ_step(int_c_r, phase_c_current_input, integrator_coefficient_r);
   wire [31:0] int_n_nxt = integ_step(int_n_r, neutral_current_input, integrator_coefficient_r);
   wire [23:0] ia_out = phase_int_on ? sat24(int_a_nxt) : phase_a_current_input;
   wire [23:0] ib_out = phase_int_on ? sat24(int_b_nxt) : phase_b_current_input;
   wire [23:0] ic_out = phase_int_on ? sat24(int_c_nxt) : phase_c_current_input;
   wire [23:0] in_out = neutral_int_on ? sat24(int_n_nxt) : neutral_current_input;

   // ****************************************
   // Output buffer
   // ****************************************
   localparam int PATH_W = 7 * 24;
   wire [PATH_W-1:0] path_in = {routed_a, routed_b, routed_c, ia_out, ib_out, ic_out, in_out};
   wire [PATH_W-1:0] path_out;

   sample_fifo #(
      .WIDTH(PATH_W),
      .DEPTH(`FIFO_DEPTH)
   ) u_sample_fifo (
      .mclk(mclk),
      .rst_n(rst_n),
      .ce(ce),
      .in_valid(adc_valid),
      .in_ready(adc_ready),
      .in_data(path_in),
      .out_valid(path_valid),
      .out_ready(path_ready),
      .out_data(path_out)
   );

   assign path_a_voltage = path_out[167:144];
   assign path_b_voltage = path_out[143:120];
   assign path_c_voltage = path_out[119:96];
   assign path_a_current = path_out[95:72];
   assign path_b_current = path_out[71:48];
   assign path_c_current = path_out[47:24];
   assign path_n_current = path_out[23:0];

   // ****************************************
   // Configuration writes
   // ****************************************
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         config_r <= `RST_CONFIG;
         third_configuration_r <= `RST_THIRD_CONFIGURATION;
         integrator_coefficient_r <= `RST_INTEGRATOR_COEFFICIENT;
         phase_a_voltage_gain_r <= `RST_VOLTAGE_GAIN;
         phase_b_voltage_gain_r <= `RST_VOLTAGE_GAIN;
         phase_c_voltage_gain_r <= `RST_VOLTAGE_GAIN;
         ready_mask_r <= 1'b0;
      end else if (ce) begin
         if (wr_cfg) config_r <= reg_wdata[15:0];
         if (wr_cfg3) third_configuration_r <= reg_wdata[7:0];
         if (wr_coef) integrator_coefficient_r <= reg_wdata[23:0];
         if (wr_gain_a) phase_a_voltage_gain_r <= reg_wdata[23:0];
         if (wr_gain_b) phase_b_voltage_gain_r <= reg_wdata[23:0];
         if (wr_gain_c) phase_c_voltage_gain_r <= reg_wdata[23:0];
         if (wr_mask) ready_mask_r <= reg_wdata[`BIT_SAMPLE_READY_FLAG];
      end
   end

   // ****************************************
   // Filter and integrator state
   // ****************************************
   // Idle integrators hold zero and never touch the coefficient
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         dc_a_r <= '0;
         dc_b_r <= '0;
         dc_c_r <= '0;
         int_a_r <= '0;
         int_b_r <= '0;
         int_c_r <= '0;
         int_n_r <= '0;
      end else if (ce && take) begin
         dc_a_r <= dc_filter_enable ? dc_a_nxt : '0;
         dc_b_r <= dc_filter_enable ? dc_b_nxt : '0;
         dc_c_r <= dc_filter_enable ? dc_c_nxt : '0;
         int_a_r <= phase_int_on ? int_a_nxt : '0;
         int_b_r <= phase_int_on ? int_b_nxt : '0;
         int_c_r <= phase_int_on ? int_c_nxt : '0;
         int_n_r <= neutral_int_on ? int_n_nxt : '0;
      end
   end

   // ****************************************
   // Waveform samples and ready flag
   // ****************************************
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         phase_a_voltage_sample_r <= '0;
         phase_b_voltage_sample_r <= '0;
         phase_c_voltage_sample_r <= '0;
      end else if (ce && take) begin
         phase_a_voltage_sample_r <= va_hpf;
         phase_b_voltage_sample_r <= vb_hpf;
         phase_c_voltage_sample_r <= vc_hpf;
      end
   end

   // Set wins over a same-cycle clear
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sample_ready_flag_r <= 1'b0;
      end else if (ce) begin
         if (take) begin
            sample_ready_flag_r <= 1'b1;
         end else if (ready_clear) begin
            sample_ready_flag_r <= 1'b0;
         end
      end
   end

   assign sample_irq_n = !(sample_ready_flag_r && ready_mask_r);

   // ****************************************
   // Read-back
   // ****************************************
   logic [31:0] rd_mux;
   always_comb begin
      case (reg_addr)
         `IDX_CONFIG: rd_mux = {16'h0000, config_r};
         `IDX_THIRD_CONFIGURATION: rd_mux = {24'h00_0000, third_configuration_r};
         `IDX_INTEGRATOR_COEFFICIENT: rd_mux = word28(integrator_coefficient_r);
         `IDX_PHASE_A_VOLTAGE_GAIN: rd_mux = word28(phase_a_voltage_gain_r);
         `IDX_PHASE_B_VOLTAGE_GAIN: rd_mux = word28(phase_b_voltage_gain_r);
         `IDX_PHASE_C_VOLTAGE_GAIN: rd_mux = word28(phase_c_voltage_gain_r);
         `IDX_PHASE_A_VOLTAGE_SAMPLE: rd_mux = {{8{phase_a_voltage_sample_r[23]}}, phase_a_voltage_sample_r};
         `IDX_PHASE_B_VOLTAGE_SAMPLE: rd_mux = {{8{phase_b_voltage_sample_r[23]}}, phase_b_voltage_sample_r};
         `IDX_PHASE_C_VOLTAGE_SAMPLE: rd_mux = {{8{phase_c_voltage_sample_r[23]}}, phase_c_voltage_sample_r};
         `IDX_FIRST_STATUS: rd_mux = 32'({sample_ready_flag_r, 17'h0_0000});
         `IDX_FIRST_INTERRUPT_MASK: rd_mux = 32'({ready_mask_r, 17'h0_0000});
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         reg_rdata <= '0;
      end else if (ce && reg_rd) begin
         reg_rdata <= rd_mux;
      end
   end
endmodule // channel_conditioning

// *** bench/cond_chk.sv ***
// Port checker for the channel conditioning top
`timescale 1ns/1ps
module cond_chk (
   // Clock and control
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic ce,
   // Register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_rdata,
   // Sample stream
   input wire logic adc_valid,
   input wire logic adc_ready,
   input wire logic path_valid,
   input wire logic path_ready,
   input wire logic [23:0] path_a_voltage,
   input wire logic sample_irq_n
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence take_s;
      ce && adc_valid && adc_ready;
   endsequence
   sequence rd_s(lo, hi);
      ce && reg_rd && reg_addr >= lo && reg_addr <= hi;
   endsequence
   AST_RESET: assert property (disable iff (1'b0) ce && !rst_n |=>
      reg_rdata == 32'h0000_0000 && !path_valid && sample_irq_n) else $error("reset state wrong");
   AST_COEF_FMT: assert property (rd_s(4'h2, 4'h5) |=> reg_rdata[31:28] == 4'h0 &&
      reg_rdata[27:24] == {4{reg_rdata[23]}}) else $error("coefficient or gain word format wrong");
   AST_SAMPLE_FMT: assert property (rd_s(4'h6, 4'h8) |=>
      reg_rdata[31:24] == {8{reg_rdata[23]}}) else $error("sample word not sign extended");
   AST_FIRST_PUSH: assert property (take_s ##0 !path_valid |=> path_valid)
      else $error("taken sample not presented");
   AST_NO_PHANTOM: assert property ($rose(path_valid) |-> $past(ce && adc_valid && adc_ready))
      else $error("output appeared without a sample");
   AST_HOLD: assert property (path_valid && !path_ready |=> path_valid && $stable(path_a_voltage))
      else $error("path output changed while held");
   AST_IRQ_CAUSE: assert property ($fell(sample_irq_n) |-> $past(ce && (adc_valid && adc_ready || reg_wr)))
      else $error("interrupt without cause");
   AST_FULL: assert property (!adc_ready |-> path_valid)
      else $error("full buffer reports empty");
endmodule // cond_chk
bind channel_conditioning cond_chk u_chk (.mclk(mclk), .rst_n(rst_n), .ce(ce), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata), .adc_valid(adc_valid),
   .adc_ready(adc_ready), .path_valid(path_valid), .path_ready(path_ready),
   .path_a_voltage(path_a_voltage), .sample_irq_n(sample_irq_n));

// *** bench/path_sink.sv ***
// Consumer of the computational path stream
`timescale 1ns/1ps
module path_sink (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Stall request from the bench
   input wire logic stall,
   // Stream side
   output logic path_ready
);
   always_ff @(posedge mclk) begin
      path_ready <= rst_n && !stall;
   end
endmodule // path_sink

// *** bench/channel_conditioning_tb_top.sv ***
// Testbench for the channel conditioning top
`timescale 1ns/1ps
module channel_conditioning_tb_top;
   logic mclk = 0, rst_n = 0, ce = 1, reg_wr = 0, reg_rd = 0, adc_valid = 0, stall = 0, rd_pend = 0, hpf = 0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, rng = 32'h0000_3b9f;
   logic [23:0] vin [3], cin [4], pv [3], pc [4], gain [3], last [3], coef;
   logic [1:0] rt [3];
   logic [31:0] acc [4], dcs [3];
   logic adc_ready, path_valid, path_ready, sample_irq_n, int_on, nint_on;
   logic [167:0] exp_p [$];
   logic [31:0] exp_rd [$];
   int failures = 0, n_tests = 0;
   always #10 mclk = ~mclk;
   channel_conditioning dut (.mclk(mclk), .rst_n(rst_n), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .adc_valid(adc_valid),
      .adc_ready(adc_ready), .phase_a_voltage_input(vin[0]), .phase_b_voltage_input(vin[1]),
      .phase_c_voltage_input(vin[2]), .phase_a_current_input(cin[0]), .phase_b_current_input(cin[1]),
      .phase_c_current_input(cin[2]), .neutral_current_input(cin[3]), .path_valid(path_valid),
      .path_ready(path_ready), .path_a_voltage(pv[0]), .path_b_voltage(pv[1]), .path_c_voltage(pv[2]),
      .path_a_current(pc[0]), .path_b_current(pc[1]), .path_c_current(pc[2]), .path_n_current(pc[3]),
      .sample_irq_n(sample_irq_n));
   path_sink u_sink (.mclk(mclk), .rst_n(rst_n), .stall(stall), .path_ready(path_ready));
   function automatic logic [31:0] xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction
   function automatic logic [23:0] sat(input longint x);
      return x > 32'sh007f_ffff ? 24'h7f_ffff : x < -32'sh0080_0000 ? 24'h80_0000 : x[23:0];
   endfunction
   function automatic int dst(input int i);
      return rt[i] == 2'b01 ? (i + 1) % 3 : rt[i] == 2'b10 ? (i + 2) % 3 : i;
   endfunction
   task automatic chk(input string what, input logic [167:0] e, input logic [167:0] g);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_rd = 0;
      adc_valid = 0;
      reg_wr = 1;
      @(negedge mclk);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      reg_addr = a;
      reg_wr = 0;
      adc_valid = 0;
      reg_rd = 1;
      exp_rd.push_back(e);
      @(negedge mclk);
   endtask
   task automatic send();
      logic [23:0] ev [3];
      logic [23:0] ec [4];
      logic [23:0] g;
      logic on;
      logic [31:0] e;
      foreach (ev[i]) ev[i] = 24'h00_0000;
      for (int i = 0; i < 4; i++) begin
         rng = xs();
         cin[i] = {{4{rng[19]}}, rng[19:0]};
         if (i < 3) vin[i] = rng[31:8];
         on = i < 3 ? int_on : nint_on;
         if (adc_ready) acc[i] = on ? acc[i] + 32'($signed(cin[i]))
            + 32'((longint'($signed(acc[i])) * $signed(coef)) >>> 23) : 32'h0000_0000;
         ec[i] = on ? sat($signed(acc[i])) : cin[i];
      end
      for (int i = 2; i >= 0; i--) begin
         g = sat((longint'($signed(vin[i])) * (longint'(32'h0080_0000) + $signed(gain[i]))) >>> 23);
         e = {g, 8'h00} - dcs[i];
         if (hpf) g = sat($signed(e) >>> 8);
         if (adc_ready) begin
            dcs[i] = hpf ? dcs[i] + 32'($signed(e) >>> 10) : 32'h0000_0000;
            last[i] = g;
         end
         ev[dst(i)] = g;
      end
      if (adc_ready) exp_p.push_back({ev[0], ev[1], ev[2], ec[0], ec[1], ec[2], ec[3]});
      reg_wr = 0;
      reg_rd = 0;
      adc_valid = 1;
      @(negedge mclk);
   endtask
   always @(posedge mclk) rd_pend <= reg_rd && rst_n;
   always @(negedge mclk) begin
      if (rd_pend) chk("reg_rdata", exp_rd.pop_front(), reg_rdata);
      if (path_valid && path_ready) chk("path", exp_p.pop_front(), {pv[0], pv[1], pv[2], pc[0], pc[1], pc[2], pc[3]});
   end
   initial begin
      #200000;
      failures++;
      end_sim();
   end
   initial begin
      foreach (vin[i]) vin[i] = 24'h00_0000;
      foreach (cin[i]) cin[i] = 24'h00_0000;
      foreach (gain[i]) gain[i] = 24'h00_0000;
      foreach (rt[i]) rt[i] = 2'b00;
      foreach (acc[i]) acc[i] = 32'h0000_0000;
      foreach (dcs[i]) dcs[i] = 32'h0000_0000;
      coef = 24'h00_0000;
      int_on = 0;
      nint_on = 0;
      repeat (2) @(negedge mclk);
      rst_n = 1;
      rd(4'h2, 32'h0000_0000);
      rd(4'h1, 32'h0000_0001);
      rd(4'h0, 32'h0000_0000);
      rd(4'hf, 32'h0000_0000);
      wr(4'h1, 32'h0000_0000);
      wr(4'h0, 32'h0000_0001);
      repeat (2) send();
      coef = 24'hff_8000;
      wr(4'h2, 32'h0fff_8000);
      rd(4'h2, 32'h0fff_8000);
      wr(4'h0, 32'h0000_0000);
      wr(4'h1, 32'h0000_0008);
      int_on = 1;
      nint_on = 1;
      repeat (3) send();
      wr(4'h0, 32'h0000_0001);
      wr(4'h1, 32'h0000_0000);
      int_on = 0;
      nint_on = 0;
      gain[0] = 24'h40_0000;
      gain[1] = 24'hc0_0000;
      gain[2] = 24'(xs());
      wr(4'h3, 32'h0040_0000);
      wr(4'h4, 32'h0fc0_0000);
      wr(4'h5, {4'h0, {4{gain[2][23]}}, gain[2]});
      rd(4'h4, 32'h0fc0_0000);
      repeat (2) send();
      wr(4'h1, 32'h0000_0001);
      hpf = 1;
      for (int k = 0; k < 5; k++) begin
         foreach (rt[i]) rt[i] = k < 4 ? 2'(k) : (i == 0 ? 2'b01 : 2'b00);
         wr(4'h0, {18'h0_0000, rt[2], rt[1], rt[0], 8'h01});
         send();
      end
      wr(4'ha, 32'h0002_0000);
      send();
      chk("sample_irq_n", 0, sample_irq_n);
      rd(4'h9, 32'h0002_0000);
      for (int i = 0; i < 3; i++) rd(4'(6 + i), {{8{last[i][23]}}, last[i]});
      ce = 0;
      wr(4'h9, 32'h0002_0000);
      chk("sample_irq_n", 0, sample_irq_n);
      ce = 1;
      wr(4'h9, 32'h0002_0000);
      chk("sample_irq_n", 1, sample_irq_n);
      rd(4'h9, 32'h0000_0000);
      stall = 1;
      reg_rd = 0;
      repeat (2) @(negedge mclk);
      repeat (9) send();
      chk("adc_ready", 0, adc_ready);
      stall = 0;
      adc_valid = 0;
      repeat (12) @(negedge mclk);
      chk("path_valid", 0, path_valid);
      end_sim();
   end
endmodule // channel_conditioning_tb_top
